//--- include/synth_seq_pkg.sv
// Constants, types and register map shared by the synthesizer sequencer files
// Overview of operation
// - An enter-receive or enter-transmit command outside calibration and settling starts oscillator calibration.
// - Calibration lasts 142 us; its done bit sits in cal_done_flags at 0x339.
// - By default a fixed 56 us settling wait follows calibration.
// - With custom_settle_enable set in operating_options, programmed waits replace the default.
// - Receive wait comes from 0x13E, transmit wait from 0x13F, independently.
// - Programmed wait spans 2 to 512 us, two microseconds per count.
// - Loop bandwidth is chosen automatically on every receive or transmit entry.
// - Receive entry always selects the 92 kHz loop bandwidth.
// - Transmit: up to 49.5 kbps gives 130 kHz, up to 129.5 kbps 174 kHz.
// - Transmit: to 179.1 kbps 226 kHz, to 239.9 kbps 305 kHz, above 382 kHz.
// - Table survives while powered but is lost on entering sleep_state.
// - Band select at 0x3DA and amplitude at 0x3DB are readable after calibration.
// - Gaussian shaping, BT 0.5, is applied to transmit bits when enabled at 0x115.
package synth_seq_pkg;

    // ========================================
    // Timing
    localparam int CLK_HZ = 50_000_000;
    localparam int US_PER_S = 1_000_000;
    localparam int TICK_CYCLES = CLK_HZ / US_PER_S;
    localparam int CAL_TIME_US = 142;
    localparam int DEFAULT_SETTLE_US = 56;
    localparam int SETTLE_STEP_US = 2;
    localparam int US_W = 10;
    localparam int DIV_W = 16;
    localparam int CYC_W = 16;

    // ========================================
    // Memory map
    localparam int ADDR_W = 11;
    localparam logic [10:0] ADDR_RATE_LOW = 11'h10c;
    localparam logic [10:0] ADDR_RATE_HIGH = 11'h10d;
    localparam logic [10:0] ADDR_RADIO_CONFIG_SEVEN = 11'h113;
    localparam logic [10:0] ADDR_RADIO_CONFIG_NINE = 11'h115;
    localparam logic [10:0] ADDR_OPERATING_OPTIONS = 11'h11a;
    localparam logic [10:0] ADDR_RX_SETTLE_DELAY = 11'h13e;
    localparam logic [10:0] ADDR_TX_SETTLE_DELAY = 11'h13f;
    localparam logic [10:0] ADDR_CAL_DONE_FLAGS = 11'h339;
    localparam logic [10:0] ADDR_OSC_BAND_RESULT = 11'h3da;
    localparam logic [10:0] ADDR_OSC_AMPLITUDE_RESULT = 11'h3db;
    localparam logic [10:0] ADDR_LUT_FIRST = 11'h010;
    localparam logic [10:0] ADDR_LUT_LAST = 11'h018;
    localparam int LUT_DEPTH = 9;
    localparam int LUT_IDX_W = 4;
    localparam logic [7:0] REG_RESET = 8'h00;
    localparam logic [7:0] READ_UNMAPPED = 8'h00;

    // ========================================
    // Fields
    localparam int CUSTOM_SETTLE_BIT = 0;
    localparam int GAUSS_EN_BIT = 7;
    localparam int CAL_DONE_BIT = 0;
    localparam int TX_BW_OPT_LSB = 4;
    localparam int TX_BW_OPT_MSB = 5;
    localparam logic [1:0] TX_BW_OPT_VALUE = 2'h2;
    localparam int RATE_HIGH_MSB = 3;
    localparam int RATE_W = 12;

    // Data rate in units of 100 bps
    localparam logic [11:0] RATE_MAX_130K = 12'h1ef;
    localparam logic [11:0] RATE_MAX_174K = 12'h50f;
    localparam logic [11:0] RATE_MAX_226K = 12'h6ff;
    localparam logic [11:0] RATE_MAX_305K = 12'h95f;

    // ========================================
    // Commands
    localparam logic [7:0] CMD_ENTER_RECEIVE = 8'h01;
    localparam logic [7:0] CMD_ENTER_TRANSMIT = 8'h02;
    localparam logic [7:0] CMD_ENTER_SLEEP = 8'h03;
    localparam logic [7:0] CMD_APPLY_CONFIG = 8'h04;
    localparam logic [7:0] CMD_ENTER_OFF = 8'h05;

    // ========================================
    // Shaper
    localparam int SHAPE_W = 3;
    localparam logic [2:0] SHAPE_FULL = 3'h4;
    localparam logic [2:0] SHAPE_ZERO = 3'h0;

    typedef enum logic [2:0] {ST_IDLE, ST_CAL, ST_SETTLE, ST_RX, ST_TX, ST_SLEEP} seq_state_type;
    typedef enum logic [2:0] {BW_92K, BW_130K, BW_174K, BW_226K, BW_305K, BW_382K} loop_bw_type;

endpackage

//--- hw/synth_phase_timer.sv
// Microsecond phase timer used for calibration and settling waits
module synth_phase_timer #(
    parameter int TICK_CYCLES = synth_seq_pkg::TICK_CYCLES
) (
    // Clock and reset
    input wire logic clk_i,
    input wire logic rst_i,
    // Control
    input wire logic start_i,
    input wire logic [synth_seq_pkg::US_W-1:0] load_us_i,
    // Status
    output logic busy_o,
    output logic done_o
);

    localparam logic [synth_seq_pkg::DIV_W-1:0] DIV_LAST = synth_seq_pkg::DIV_W'(TICK_CYCLES - 1);

    typedef struct packed {
        logic busy;
        logic done;
        logic [synth_seq_pkg::DIV_W-1:0] div;
        logic [synth_seq_pkg::US_W-1:0] us_left;
    } timer_state_type;

    timer_state_type q;
    timer_state_type d;

    // ========================================
    // Divider runs only while busy, so a wait is exactly load times tick
    always_comb begin
        d = q;
        d.done = 1'b0;
        if (start_i) begin
            d.busy = 1'b1;
            d.div = '0;
            d.us_left = load_us_i;
        end else if (q.busy) begin
            if (q.div == DIV_LAST) begin
                d.div = '0;
                if (q.us_left <= synth_seq_pkg::US_W'(1)) begin
                    d.busy = 1'b0;
                    d.done = 1'b1;
                end else begin
                    d.us_left = q.us_left - synth_seq_pkg::US_W'(1);
                end
            end else begin
                d.div = q.div + synth_seq_pkg::DIV_W'(1);
            end
        end
    end

    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            q <= '0;
        end else begin
            q <= d;
        end
    end

    assign busy_o = q.busy;
    assign done_o = q.done;

    // ========================================
    // Checks
    default clocking cb @(posedge clk_i);
    endclocking
    default disable iff (rst_i);

    a_start_sets_busy: assert property (start_i |=> busy_o)
        else $error("timer not busy after start");
    a_done_ends_busy: assert property (done_o |-> !busy_o && $past(busy_o))
        else $error("done without a running wait");
    a_done_single: assert property (done_o |=> !done_o)
        else $error("done longer than one cycle");

endmodule

//--- hw/synth_cal_settle_sequencer.sv
// Synthesizer calibration, settling and loop bandwidth sequencer with its registers
module synth_cal_settle_sequencer #(
    parameter int TICK_CYCLES = synth_seq_pkg::TICK_CYCLES,
    parameter int CAL_US = synth_seq_pkg::CAL_TIME_US
) (
    // Clock and reset
    input wire logic REF_CLK_I,
    input wire logic RESET_I,
    // Command port
    input wire logic CMD_VALID_I,
    input wire logic [7:0] CMD_CODE_I,
    // Memory access port
    input wire logic MEM_WR_I,
    input wire logic MEM_RD_I,
    input wire logic [synth_seq_pkg::ADDR_W-1:0] MEM_ADDR_I,
    input wire logic [7:0] MEM_WDATA_I,
    output logic [7:0] MEM_RDATA_O,
    output logic MEM_RVALID_O,
    // Oscillator calibration results
    input wire logic [7:0] VCO_BAND_I,
    input wire logic [7:0] VCO_AMPL_I,
    // Transmit bit stream
    input wire logic TX_BIT_I,
    input wire logic TX_BIT_STB_I,
    output logic [synth_seq_pkg::SHAPE_W-1:0] TX_SHAPED_O,
    // Synthesizer control and state
    output logic CAL_BUSY_O,
    output logic SETTLING_O,
    output logic RX_ACTIVE_O,
    output logic TX_ACTIVE_O,
    output logic SLEEP_O,
    output logic STATE_ENTERED_O,
    output logic [2:0] SYNTH_BW_O,
    output logic TX_LUT_SEL_O
);

    localparam int CAL_CYC = CAL_US * TICK_CYCLES;
    // Calibration phase length in clock cycles, timer latency excluded
    localparam logic [synth_seq_pkg::CYC_W-1:0] CYC_W_CAL = synth_seq_pkg::CYC_W'(CAL_CYC);

    typedef struct packed {
        synth_seq_pkg::seq_state_type st;
        logic dir_tx;
        logic [7:0] rate_low;
        logic [7:0] rate_high;
        logic [7:0] radio_config_seven;
        logic [7:0] radio_config_nine;
        logic [7:0] operating_options;
        logic [7:0] rx_settle_delay;
        logic [7:0] tx_settle_delay;
        logic [7:0] cal_done_flags;
        logic [7:0] osc_band_result;
        logic [7:0] osc_amplitude_result;
        logic [synth_seq_pkg::US_W-1:0] settle_len;
        synth_seq_pkg::loop_bw_type bw;
        logic opt_applied;
        logic [synth_seq_pkg::LUT_DEPTH-1:0][7:0] lut;
        logic [7:0] rdata;
        logic rvalid;
        logic entered;
        logic [2:0] hist;
        logic [synth_seq_pkg::SHAPE_W-1:0] shaped;
        logic [synth_seq_pkg::CYC_W-1:0] phase_cyc;
    } seq_reg_type;

    seq_reg_type q;
    seq_reg_type d;

    logic timer_start;
    logic [synth_seq_pkg::US_W-1:0] timer_load;
    logic timer_busy;
    logic timer_done;
    logic cmd_ok;
    logic [synth_seq_pkg::RATE_W-1:0] rate_w;

    // ========================================
    // Decoding helpers
    function automatic logic is_lut(input logic [synth_seq_pkg::ADDR_W-1:0] addr);
        return (addr >= synth_seq_pkg::ADDR_LUT_FIRST) && (addr <= synth_seq_pkg::ADDR_LUT_LAST);
    endfunction

    function automatic logic [synth_seq_pkg::LUT_IDX_W-1:0] lut_index(
        input logic [synth_seq_pkg::ADDR_W-1:0] addr);
        logic [synth_seq_pkg::ADDR_W-1:0] diff;
        diff = addr - synth_seq_pkg::ADDR_LUT_FIRST;
        return diff[synth_seq_pkg::LUT_IDX_W-1:0];
    endfunction

    function automatic logic [synth_seq_pkg::US_W-1:0] settle_us(input logic custom,
        input logic is_tx, input logic [7:0] rx_count, input logic [7:0] tx_count);
        logic [7:0] sel;
        sel = is_tx ? tx_count : rx_count;
        if (custom) begin
            return synth_seq_pkg::US_W'((int'(sel) + 1) * synth_seq_pkg::SETTLE_STEP_US);
        end
        return synth_seq_pkg::US_W'(synth_seq_pkg::DEFAULT_SETTLE_US);
    endfunction

    function automatic synth_seq_pkg::loop_bw_type select_bw(input logic is_tx,
        input logic [synth_seq_pkg::RATE_W-1:0] rate);
        if (!is_tx) begin
            return synth_seq_pkg::BW_92K;
        end else if (rate <= synth_seq_pkg::RATE_MAX_130K) begin
            return synth_seq_pkg::BW_130K;
        end else if (rate <= synth_seq_pkg::RATE_MAX_174K) begin
            return synth_seq_pkg::BW_174K;
        end else if (rate <= synth_seq_pkg::RATE_MAX_226K) begin
            return synth_seq_pkg::BW_226K;
        end else if (rate <= synth_seq_pkg::RATE_MAX_305K) begin
            return synth_seq_pkg::BW_305K;
        end
        return synth_seq_pkg::BW_382K;
    endfunction

    // Three-tap 1-2-1 kernel approximates a BT 0.5 Gaussian at one sample per bit
    function automatic logic [synth_seq_pkg::SHAPE_W-1:0] shape(input logic enable,
        input logic [2:0] h);
        if (enable) begin
            return synth_seq_pkg::SHAPE_W'({2'b00, h[0]} + {1'b0, h[1], 1'b0} + {2'b00, h[2]});
        end
        return h[0] ? synth_seq_pkg::SHAPE_FULL : synth_seq_pkg::SHAPE_ZERO;
    endfunction

    assign rate_w = {q.rate_high[synth_seq_pkg::RATE_HIGH_MSB:0], q.rate_low};
    // Commands during calibration or settling are dropped, not queued
    assign cmd_ok = (q.st != synth_seq_pkg::ST_CAL) && (q.st != synth_seq_pkg::ST_SETTLE);

    // ========================================
    // Next state
    always_comb begin
        d = q;
        d.rvalid = 1'b0;
        d.entered = 1'b0;
        timer_start = 1'b0;
        timer_load = '0;

        if (MEM_WR_I) begin
            if (is_lut(MEM_ADDR_I)) begin
                d.lut[lut_index(MEM_ADDR_I)] = MEM_WDATA_I;
            end else begin
                case (MEM_ADDR_I)
                    synth_seq_pkg::ADDR_RATE_LOW: begin
                        d.rate_low = MEM_WDATA_I;
                    end
                    synth_seq_pkg::ADDR_RATE_HIGH: begin
                        d.rate_high = MEM_WDATA_I;
                    end
                    synth_seq_pkg::ADDR_RADIO_CONFIG_SEVEN: begin
                        d.radio_config_seven = MEM_WDATA_I;
                    end
                    synth_seq_pkg::ADDR_RADIO_CONFIG_NINE: begin
                        d.radio_config_nine = MEM_WDATA_I;
                    end
                    synth_seq_pkg::ADDR_OPERATING_OPTIONS: begin
                        d.operating_options = MEM_WDATA_I;
                    end
                    synth_seq_pkg::ADDR_RX_SETTLE_DELAY: begin
                        d.rx_settle_delay = MEM_WDATA_I;
                    end
                    synth_seq_pkg::ADDR_TX_SETTLE_DELAY: begin
                        d.tx_settle_delay = MEM_WDATA_I;
                    end
                    default: begin
                    end
                endcase
            end
        end

        if (MEM_RD_I) begin
            d.rvalid = 1'b1;
            if (is_lut(MEM_ADDR_I)) begin
                d.rdata = q.lut[lut_index(MEM_ADDR_I)];
            end else begin
                case (MEM_ADDR_I)
                    synth_seq_pkg::ADDR_RATE_LOW: d.rdata = q.rate_low;
                    synth_seq_pkg::ADDR_RATE_HIGH: d.rdata = q.rate_high;
                    synth_seq_pkg::ADDR_RADIO_CONFIG_SEVEN: d.rdata = q.radio_config_seven;
                    synth_seq_pkg::ADDR_RADIO_CONFIG_NINE: d.rdata = q.radio_config_nine;
                    synth_seq_pkg::ADDR_OPERATING_OPTIONS: d.rdata = q.operating_options;
                    synth_seq_pkg::ADDR_RX_SETTLE_DELAY: d.rdata = q.rx_settle_delay;
                    synth_seq_pkg::ADDR_TX_SETTLE_DELAY: d.rdata = q.tx_settle_delay;
                    synth_seq_pkg::ADDR_CAL_DONE_FLAGS: d.rdata = q.cal_done_flags;
                    synth_seq_pkg::ADDR_OSC_BAND_RESULT: d.rdata = q.osc_band_result;
                    synth_seq_pkg::ADDR_OSC_AMPLITUDE_RESULT: d.rdata = q.osc_amplitude_result;
                    default: d.rdata = synth_seq_pkg::READ_UNMAPPED;
                endcase
            end
        end

        if (TX_BIT_STB_I) begin
            d.hist = {q.hist[1:0], TX_BIT_I};
            d.shaped = shape(q.radio_config_nine[synth_seq_pkg::GAUSS_EN_BIT], d.hist);
        end

        case (q.st)
            synth_seq_pkg::ST_CAL: begin
                if (timer_done) begin
                    d.cal_done_flags[synth_seq_pkg::CAL_DONE_BIT] = 1'b1;
                    d.osc_band_result = VCO_BAND_I;
                    d.osc_amplitude_result = VCO_AMPL_I;
                    d.settle_len = settle_us(
                        q.operating_options[synth_seq_pkg::CUSTOM_SETTLE_BIT],
                        q.dir_tx, q.rx_settle_delay, q.tx_settle_delay);
                    d.st = synth_seq_pkg::ST_SETTLE;
                    timer_start = 1'b1;
                    timer_load = d.settle_len;
                end
            end
            synth_seq_pkg::ST_SETTLE: begin
                if (timer_done) begin
                    d.st = q.dir_tx ? synth_seq_pkg::ST_TX : synth_seq_pkg::ST_RX;
                    d.bw = select_bw(q.dir_tx, rate_w);
                    d.entered = 1'b1;
                end
            end
            synth_seq_pkg::ST_IDLE, synth_seq_pkg::ST_RX, synth_seq_pkg::ST_TX,
            synth_seq_pkg::ST_SLEEP: begin
                if (CMD_VALID_I) begin
                    case (CMD_CODE_I)
                        synth_seq_pkg::CMD_ENTER_RECEIVE, synth_seq_pkg::CMD_ENTER_TRANSMIT: begin
                            d.st = synth_seq_pkg::ST_CAL;
                            d.dir_tx = (CMD_CODE_I == synth_seq_pkg::CMD_ENTER_TRANSMIT);
                            d.cal_done_flags[synth_seq_pkg::CAL_DONE_BIT] = 1'b0;
                            timer_start = 1'b1;
                            timer_load = synth_seq_pkg::US_W'(CAL_US);
                        end
                        synth_seq_pkg::CMD_ENTER_SLEEP: begin
                            d.st = synth_seq_pkg::ST_SLEEP;
                            d.lut = '0;
                        end
                        synth_seq_pkg::CMD_APPLY_CONFIG: begin
                            d.opt_applied = (q.radio_config_seven[synth_seq_pkg::TX_BW_OPT_MSB:
                                synth_seq_pkg::TX_BW_OPT_LSB] == synth_seq_pkg::TX_BW_OPT_VALUE);
                        end
                        synth_seq_pkg::CMD_ENTER_OFF: begin
                            d.st = synth_seq_pkg::ST_IDLE;
                        end
                        default: begin
                        end
                    endcase
                end
            end
            default: begin
                d.st = synth_seq_pkg::ST_IDLE;
            end
        endcase

        // Cycle count of the current timed phase, read only by the checks
        if (d.st != q.st) begin
            d.phase_cyc = '0;
        end else if (!cmd_ok) begin
            d.phase_cyc = q.phase_cyc + synth_seq_pkg::CYC_W'(1);
        end
    end

    always_ff @(posedge REF_CLK_I or posedge RESET_I) begin
        if (RESET_I) begin
            q <= '0;
        end else begin
            q <= d;
        end
    end

    // ========================================
    // Phase timer
    synth_phase_timer #(
        .TICK_CYCLES(TICK_CYCLES)
    ) u_timer (
        .clk_i(REF_CLK_I),
        .rst_i(RESET_I),
        .start_i(timer_start),
        .load_us_i(timer_load),
        .busy_o(timer_busy),
        .done_o(timer_done)
    );

    // ========================================
    // Outputs
    assign MEM_RDATA_O = q.rdata;
    assign MEM_RVALID_O = q.rvalid;
    assign TX_SHAPED_O = q.shaped;
    assign CAL_BUSY_O = (q.st == synth_seq_pkg::ST_CAL);
    assign SETTLING_O = (q.st == synth_seq_pkg::ST_SETTLE);
    assign RX_ACTIVE_O = (q.st == synth_seq_pkg::ST_RX);
    assign TX_ACTIVE_O = (q.st == synth_seq_pkg::ST_TX);
    assign SLEEP_O = (q.st == synth_seq_pkg::ST_SLEEP);
    assign STATE_ENTERED_O = q.entered;
    assign SYNTH_BW_O = q.bw;
    assign TX_LUT_SEL_O = q.opt_applied;

    // ========================================
    // Checks
    default clocking cb @(posedge REF_CLK_I);
    endclocking
    default disable iff (RESET_I);

    sequence s_enter_cmd;
        CMD_VALID_I && cmd_ok && ((CMD_CODE_I == synth_seq_pkg::CMD_ENTER_RECEIVE)
            || (CMD_CODE_I == synth_seq_pkg::CMD_ENTER_TRANSMIT));
    endsequence

    sequence s_cal_end;
        (q.st == synth_seq_pkg::ST_CAL) && timer_done;
    endsequence

    sequence s_settle_end;
        (q.st == synth_seq_pkg::ST_SETTLE) && timer_done;
    endsequence

    a_cal_starts: assert property (s_enter_cmd |=> CAL_BUSY_O && timer_busy)
        else $error("entry command did not start calibration");
    a_cal_length: assert property (s_cal_end |-> q.phase_cyc == CYC_W_CAL)
        else $error("calibration length wrong");
    a_cal_flag_low: assert property (CAL_BUSY_O |-> !q.cal_done_flags[0])
        else $error("calibration status done during calibration");
    a_cal_to_settle: assert property (s_cal_end |=> SETTLING_O && q.cal_done_flags[0])
        else $error("settling did not follow calibration");
    a_settle_default: assert property ($rose(SETTLING_O)
        && !$past(q.operating_options[0]) |-> q.settle_len == 10'h038)
        else $error("default settling wait not 56 us");
    a_settle_custom: assert property ($rose(SETTLING_O) && !q.dir_tx
        && $past(q.operating_options[0])
        |-> q.settle_len == {1'b0, $past(q.rx_settle_delay), 1'b0} + 10'h002)
        else $error("receive settling wait not from its register");
    a_settle_length: assert property (s_settle_end
        |-> q.phase_cyc == synth_seq_pkg::CYC_W'(int'(q.settle_len) * TICK_CYCLES))
        else $error("settling length wrong");
    a_rx_bandwidth: assert property (RX_ACTIVE_O |-> q.bw == synth_seq_pkg::BW_92K)
        else $error("receive bandwidth not 92 kHz");
    a_tx_low_rate: assert property ($rose(TX_ACTIVE_O) && $past(rate_w) <= 12'h1ef
        |-> q.bw == synth_seq_pkg::BW_130K)
        else $error("low rate transmit bandwidth wrong");
    a_tx_high_rate: assert property ($rose(TX_ACTIVE_O) && $past(rate_w) > 12'h95f
        |-> q.bw == synth_seq_pkg::BW_382K)
        else $error("high rate transmit bandwidth wrong");
    a_entry_order: assert property ($rose(RX_ACTIVE_O || TX_ACTIVE_O)
        |-> STATE_ENTERED_O && $past(SETTLING_O))
        else $error("state entered without settling");
    a_sleep_clears: assert property ($rose(SLEEP_O) |-> q.lut == '0)
        else $error("table kept across sleep entry");
    a_band_capture: assert property (s_cal_end |=> q.osc_band_result == $past(VCO_BAND_I))
        else $error("band select not captured");
    a_gauss_shape: assert property (TX_BIT_STB_I && q.radio_config_nine[7] && TX_BIT_I
        && q.hist == 3'h0 |=> TX_SHAPED_O == 3'h1)
        else $error("shaped edge not softened");

endmodule

//--- bench/host_model.sv
// Host processor model for the command and memory ports
module host_model (
    // Answers
    input wire logic clk_i,
    input wire logic [7:0] rdata_i,
    input wire logic rvalid_i,
    // Requests
    output logic wr_o,
    output logic rd_o,
    output logic [10:0] addr_o,
    output logic [7:0] wdata_o,
    output logic cmd_o,
    output logic [7:0] code_o
);
    timeunit 1ns;
    timeprecision 1ps;
    initial {wr_o, rd_o, addr_o, wdata_o, cmd_o, code_o} = '0;
    task automatic wr(input logic [10:0] a, input logic [7:0] d);
        @(posedge clk_i) #1;
        {wr_o, addr_o, wdata_o} = {1'b1, a, d};
        @(posedge clk_i) #1;
        // Released data is inverted so a stale byte never looks valid
        {wr_o, wdata_o} = {1'b0, ~d};
    endtask
    task automatic rd(input logic [10:0] a, output logic [7:0] d);
        @(posedge clk_i) #1;
        {rd_o, addr_o} = {1'b1, a};
        @(posedge clk_i) #1;
        rd_o = 1'b0;
        d = (rvalid_i === 1'b1) ? rdata_i : 8'hxx;
    endtask
    task automatic cmd(input logic [7:0] c);
        @(posedge clk_i) #1;
        {cmd_o, code_o} = {1'b1, c};
        @(posedge clk_i) #1;
        cmd_o = 1'b0;
    endtask
    task automatic lut(input logic [71:0] t);
        for (int i = 0; i < 9; i++) wr(11'h010 + 11'(i), t[71 - 8 * i -: 8]);
    endtask
endmodule

//--- bench/tb.sv
// Self-checking bench for the synthesizer sequencer
`define CHK(a, b) begin cmp_count++; if ((a) !== (b)) begin miscompares++; \
    $display("[FAIL] %0t got %h exp %h", $time, a, b); end end
module tb;
    timeunit 1ns;
    timeprecision 1ps;
    logic clk, rst, wr, rd, rv, cv, stb, tbit, busy, settl, rxa, txa, slp, ent, sel;
    logic [10:0] addr;
    logic [7:0] wd, rdat, code, d;
    logic [7:0] band = 8'h5a;
    logic [7:0] ampl = 8'ha5;
    logic [2:0] shp, bw;
    logic [11:0] rt[8] = '{12'h1ef, 12'h1f0, 12'h50f, 12'h510, 12'h6ff, 12'h700, 12'h95f, 12'h960};
    int miscompares = 0, cmp_count = 0;
    host_model host (.clk_i(clk), .rdata_i(rdat), .rvalid_i(rv), .wr_o(wr), .rd_o(rd),
        .addr_o(addr), .wdata_o(wd), .cmd_o(cv), .code_o(code));
    // Short tick and calibration keep the run brief
    synth_cal_settle_sequencer #(.TICK_CYCLES(2), .CAL_US(5)) dut (.REF_CLK_I(clk),
        .RESET_I(rst), .CMD_VALID_I(cv), .CMD_CODE_I(code), .MEM_WR_I(wr), .MEM_RD_I(rd),
        .MEM_ADDR_I(addr), .MEM_WDATA_I(wd), .MEM_RDATA_O(rdat), .MEM_RVALID_O(rv),
        .VCO_BAND_I(band), .VCO_AMPL_I(ampl), .TX_BIT_I(tbit), .TX_BIT_STB_I(stb),
        .TX_SHAPED_O(shp), .CAL_BUSY_O(busy), .SETTLING_O(settl), .RX_ACTIVE_O(rxa),
        .TX_ACTIVE_O(txa), .SLEEP_O(slp), .STATE_ENTERED_O(ent), .SYNTH_BW_O(bw),
        .TX_LUT_SEL_O(sel));
    task automatic report_and_stop;
        $display("Comparisons %0d mismatches %0d", cmp_count, miscompares);
        if (miscompares == 0 && cmp_count > 0)
            $display("RESULT: PASS");
        else
            $display("RESULT: FAIL");
        $finish;
    endtask
    // ========================================
    // State entry: calibration length, settle length, bandwidth
    task automatic run(input logic [7:0] c, input int st, input logic [2:0] b);
        int nc, ns;
        host.cmd(c);
        host.rd(11'h339, d);
        `CHK(d[0], 1'b0)
        nc = 2;
        ns = 0;
        while (busy === 1'b1 && nc < 3000) begin nc++; @(posedge clk) #1; end
        while (settl === 1'b1 && ns < 3000) begin ns++; @(posedge clk) #1; end
        `CHK(nc, 11)
        // Settling also carries the one cycle of timer latency
        `CHK(ns, st + 1)
        `CHK(ent, 1'b1)
        `CHK(bw, b)
        `CHK(c == 8'h01 ? rxa : txa, 1'b1)
        host.rd(11'h339, d);
        `CHK(d[0], 1'b1)
    endtask
    task automatic sh(input logic b, input int e);
        @(posedge clk) #1;
        {stb, tbit} = {1'b1, b};
        @(posedge clk) #1;
        stb = 1'b0;
        if (e < 5) `CHK(shp, 3'(e))
    endtask
    task automatic chk_lut(input logic [71:0] t);
        for (int i = 0; i < 9; i++) begin
            host.rd(11'h010 + 11'(i), d);
            `CHK(d, t[71 - 8 * i -: 8])
        end
    endtask
    initial begin
        clk = 0;
        forever #10 clk = ~clk;
    end
    initial begin
        #400us;
        miscompares++;
        report_and_stop();
    end
    initial begin
        {rst, stb, tbit} = 3'b100;
        repeat (16) @(posedge clk);
        #1 rst = 0;
        host.wr(11'h339, 8'hff);
        foreach (rt[i]) if (i < 3) begin
            host.rd(i == 0 ? 11'h339 : i == 1 ? 11'h11a : 11'h7ff, d);
            `CHK(d, 8'h00)
        end
        run(8'h01, 112, 3'h0);
        host.rd(11'h3da, d);
        `CHK(d, 8'h5a)
        host.rd(11'h3db, d);
        `CHK(d, 8'ha5)
        host.wr(11'h11a, 8'h01);
        host.wr(11'h13e, 8'hff);
        host.wr(11'h13f, 8'h00);
        {band, ampl} = 16'h3cc3;
        run(8'h01, 1024, 3'h0);
        host.rd(11'h3da, d);
        `CHK(d, band)
        host.rd(11'h3db, d);
        `CHK(d, ampl)
        foreach (rt[i]) begin
            host.wr(11'h10c, rt[i][7:0]);
            host.wr(11'h10d, {4'h0, rt[i][11:8]});
            run(8'h02, 4, 3'((i + 1) / 2 + 1));
        end
        host.wr(11'h113, 8'h20);
        host.cmd(8'h04);
        @(posedge clk) #1;
        `CHK(sel, 1'b1)
        host.lut(72'h1010_0f0f_1f0f_1f33_22);
        chk_lut(72'h1010_0f0f_1f0f_1f33_22);
        host.wr(11'h115, 8'h80);
        sh(1, 1);
        sh(1, 3);
        sh(1, 4);
        sh(0, 3);
        host.wr(11'h115, 8'h00);
        sh(1, 4);
        sh(0, 0);
        host.lut(72'h2020_0f0f_1f05_1f33_22);
        chk_lut(72'h2020_0f0f_1f05_1f33_22);
        host.cmd(8'h03);
        `CHK(slp, 1'b1)
        chk_lut(72'h0);
        report_and_stop();
    end
endmodule
